// file: hw/cvc_capture.sv
// Purpose: counter value capture unit for one channel, avalon-mm slave
// Assumes: counter value and run level come from logic on mclk_i
// Notes: external input and compare hits are asynchronous and synchronised here
//
// Behaviour
// [R1] trigger select 0 takes events from this channel's external input.
// [R2] controller config assigns capture to the input; otherwise no input capture.
// [R3] trigger select 1 captures on other channel's compare hits a and b.
// [R4] trigger select 1 ignores the external input entirely.
// [R5] controller gives trigger select 0 or 1; others are input faults.
// [R6] controller gives module index 0 to 31.
// [R7] controller gives channel 1 or 2.
// [R8] busy rises after run rises and the function switches on.
// [R9] busy falls when run falls and the function switches off.
// [R10] capture registers load only while busy, on a valid event.
// [R11] capture registers are signed and reset to zero.
// [R12] done flag sets only once its capture value is written.
// [R13] done flags clear on run fall; software may also clear them.
// [R14] fault flag and code raise on bad input, clear on run fall.
// [R15] select 0: rise loads a, fall loads b; select 1: hit a, hit b.
// [R16] trigger select is sampled once when the function starts.
// [R17] new captures overwrite even while done flags stay set.
// [R18] with the counter stopped, captured values simply stay frozen.
// [R19] events are synchronised; value recorded in the detection cycle.
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`default_nettype none

`include "cvc_cfg.svh"

module cvc_capture #(
  parameter logic [7:0] LOCAL_INDEX = 8'h00,
  parameter logic [7:0] CHANNEL_NO = 8'h01
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire logic [31:0] counter_value_i,
  input wire logic counter_run_i,
  input wire logic ext_capture_i,
  input wire logic ext_capture_assigned_i,
  input wire logic compare_hit_a_i,
  input wire logic compare_hit_b_i
);

  // ==========================================================
  // state
  typedef struct packed {
    cvc_pkg::cvc_state_e state;
    logic [31:0] ctrl;
    logic run_prev;
    logic trg_sel;
    logic ext_prev;
    logic [1:0] hit_prev;
    logic signed [31:0] cap_a;
    logic signed [31:0] cap_b;
    logic done_a;
    logic done_b;
    logic fault;
    logic [7:0] fault_code;
    logic waitreq;
    logic [31:0] rdata;
  } cvc_core_s;

  localparam cvc_core_s CORE_RST = '{
    state: cvc_pkg::ST_IDLE,
    ctrl: `CVC_CTRL_RST,
    run_prev: 1'b0,
    trg_sel: 1'b0,
    ext_prev: 1'b0,
    hit_prev: 2'h0,
    cap_a: 32'sh0,
    cap_b: 32'sh0,
    done_a: 1'b0,
    done_b: 1'b0,
    fault: 1'b0,
    fault_code: cvc_pkg::FC_NONE,
    waitreq: 1'b1,
    rdata: 32'h0
  };

  cvc_core_s q;
  cvc_core_s d;

  logic [2:0] sync_lvl;
  logic [`CVC_IRQ_N-1:0] irq_set;
  logic [`CVC_IRQ_N-1:0] irq_stat;
  logic [`CVC_IRQ_N-1:0] irq_en;
  logic irq_line;
  logic wr_go;
  logic irq_clr_we;
  logic irq_en_we;

  // ==========================================================
  // helpers
  // a bus write counts only at the edge where waitrequest is seen low
  function automatic logic cvc_wr_hit(input logic go, input logic [7:0] addr, input logic [7:0] off);
    return go && (addr == off);
  endfunction

  // level edge against its copy one cycle older
  function automatic logic cvc_edge(input logic now_v, input logic prev_v, input logic rising);
    return rising ? (now_v & ~prev_v) : (~now_v & prev_v);
  endfunction

  // run rise request check; the first failing test picks the code
  function automatic logic [7:0] cvc_req_fault(input logic [7:0] trg, input logic [7:0] mods,
                                               input logic [7:0] chan);
    logic [7:0] r;
    r = cvc_pkg::FC_NONE;
    if (trg > `CVC_TRG_MAX) // R5
    begin
      r = cvc_pkg::FC_BAD_TRG; // R14
    end
    else if (mods > `CVC_MOD_MAX) // R6
    begin
      r = cvc_pkg::FC_BAD_MOD; // R14
    end
    else if (chan < `CVC_CHAN_MIN || chan > `CVC_CHAN_MAX) // R7
    begin
      r = cvc_pkg::FC_BAD_CHAN; // R14
    end
    else if (mods != LOCAL_INDEX || chan != CHANNEL_NO)
    begin
      r = cvc_pkg::FC_NOT_FOUND; // R14
    end
    return r;
  endfunction

  // ==========================================================
  // input synchronisers
  cvc_sync #(
    .W(3)
  ) u_sync (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i({compare_hit_b_i, compare_hit_a_i, ext_capture_i}), // R19
    .level_o(sync_lvl)
  );

  // ==========================================================
  // interrupt status
  cvc_irq #(
    .N(`CVC_IRQ_N)
  ) u_irq (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .set_i(irq_set),
    .clr_we_i(irq_clr_we),
    .en_we_i(irq_en_we),
    .wdata_i(avs_writedata_i[`CVC_IRQ_N-1:0]),
    .status_o(irq_stat),
    .enable_o(irq_en),
    .irq_o(irq_line)
  );

  // a write lands at the edge where waitrequest is seen low
  assign wr_go = avs_write_i & ~q.waitreq;
  assign irq_clr_we = cvc_wr_hit(wr_go, avs_address_i, `CVC_OFF_IRQ_CLR);
  assign irq_en_we = cvc_wr_hit(wr_go, avs_address_i, `CVC_OFF_IRQ_EN);

  // ==========================================================
  // next state
  always_comb
  begin
    logic run;
    logic run_rise;
    logic run_fall;
    logic ext_rise;
    logic ext_fall;
    logic [1:0] hit_rise;
    logic ev_a;
    logic ev_b;
    logic ev_fault;
    logic [7:0] trg_req;
    logic [7:0] mod_req;
    logic [7:0] chan_req;
    logic [31:0] status;
    d = q;
    status = 32'h0;
    run = q.ctrl[`CVC_CTRL_RUN];
    run_rise = cvc_edge(run, q.run_prev, 1'b1);
    run_fall = cvc_edge(run, q.run_prev, 1'b0);
    ext_rise = cvc_edge(sync_lvl[0], q.ext_prev, 1'b1);
    ext_fall = cvc_edge(sync_lvl[0], q.ext_prev, 1'b0);
    hit_rise[0] = cvc_edge(sync_lvl[1], q.hit_prev[0], 1'b1);
    hit_rise[1] = cvc_edge(sync_lvl[2], q.hit_prev[1], 1'b1);
    ev_a = 1'b0;
    ev_b = 1'b0;
    ev_fault = 1'b0;
    trg_req = q.ctrl[`CVC_CTRL_TRG_LSB +: 8];
    mod_req = q.ctrl[`CVC_CTRL_MOD_LSB +: 8];
    chan_req = q.ctrl[`CVC_CTRL_CHAN_LSB +: 8];
    d.run_prev = run;
    d.ext_prev = sync_lvl[0];
    d.hit_prev = sync_lvl[2:1];

    // software done clear first, so a capture in the same cycle wins
    if (cvc_wr_hit(wr_go, avs_address_i, `CVC_OFF_DONE_CLR))
    begin
      d.done_a = q.done_a & ~avs_writedata_i[0]; // R13
      d.done_b = q.done_b & ~avs_writedata_i[1]; // R13
    end

    // function sequencer
    case (q.state)
      cvc_pkg::ST_IDLE:
      begin
        if (run_rise)
        begin
          d.fault_code = cvc_req_fault(trg_req, mod_req, chan_req); // R5 R6 R7 R14
          if (d.fault_code != cvc_pkg::FC_NONE)
          begin
            d.fault = 1'b1; // R14
            ev_fault = 1'b1;
            d.state = cvc_pkg::ST_FAULT;
          end
          else
          begin
            d.trg_sel = trg_req[0]; // R16
            d.state = cvc_pkg::ST_ACTIVE; // R8
          end
        end
      end
      cvc_pkg::ST_ACTIVE:
      begin
        if (run_fall)
        begin
          d.state = cvc_pkg::ST_IDLE; // R9
          d.done_a = 1'b0; // R13
          d.done_b = 1'b0; // R13
        end
        else
        begin
          if (!q.trg_sel)
          begin
            // input path only counts when the config routes it here
            ev_a = ext_rise & ext_capture_assigned_i; // R1 R2 R15
            ev_b = ext_fall & ext_capture_assigned_i; // R1 R2 R15
          end
          else
          begin
            // external input deliberately not looked at
            ev_a = hit_rise[0]; // R3 R4 R15
            ev_b = hit_rise[1]; // R3 R4 R15
          end
        end
      end
      cvc_pkg::ST_FAULT:
      begin
        if (run_fall)
        begin
          d.state = cvc_pkg::ST_IDLE;
          d.fault = 1'b0; // R14
          d.fault_code = cvc_pkg::FC_NONE; // R14
          d.done_a = 1'b0; // R13
          d.done_b = 1'b0; // R13
        end
      end
      default:
      begin
        d.state = cvc_pkg::ST_IDLE;
      end
    endcase

    // stopped counter just yields a frozen value, no special case
    if (ev_a)
    begin
      d.cap_a = counter_value_i; // R10 R11 R17 R18 R19
      d.done_a = 1'b1; // R12
    end
    if (ev_b)
    begin
      d.cap_b = counter_value_i; // R10 R11 R17 R18 R19
      d.done_b = 1'b1; // R12
    end

    // control writes
    if (cvc_wr_hit(wr_go, avs_address_i, `CVC_OFF_CTRL))
    begin
      d.ctrl = cvc_pkg::cvc_be_merge(q.ctrl, avs_writedata_i, avs_byteenable_i) & `CVC_CTRL_MASK;
    end

    // status word
    status[`CVC_ST_ACTIVE] = (q.state == cvc_pkg::ST_ACTIVE); // R8 R9
    status[`CVC_ST_DONE_A] = q.done_a;
    status[`CVC_ST_DONE_B] = q.done_b;
    status[`CVC_ST_FAULT] = q.fault;
    status[`CVC_ST_CNT_RUN] = counter_run_i;
    status[`CVC_ST_TRG] = q.trg_sel;
    status[`CVC_ST_CODE_LSB +: 8] = q.fault_code;

    // bus handshake: one wait cycle, then answer
    if (avs_read_i || avs_write_i)
    begin
      d.waitreq = ~q.waitreq;
    end
    else
    begin
      d.waitreq = 1'b1;
    end
    if (avs_read_i && q.waitreq)
    begin
      case (avs_address_i)
        `CVC_OFF_CTRL: d.rdata = q.ctrl;
        `CVC_OFF_STATUS: d.rdata = status;
        `CVC_OFF_CAP_A: d.rdata = q.cap_a;
        `CVC_OFF_CAP_B: d.rdata = q.cap_b;
        `CVC_OFF_IRQ_STAT: d.rdata = {29'h0, irq_stat};
        `CVC_OFF_IRQ_EN: d.rdata = {29'h0, irq_en};
        default: d.rdata = 32'h0;
      endcase
    end

    irq_set = '0;
    irq_set[`CVC_IRQ_CAP_A] = ev_a;
    irq_set[`CVC_IRQ_CAP_B] = ev_b;
    irq_set[`CVC_IRQ_FAULT] = ev_fault;
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      q <= CORE_RST;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.waitreq;
  assign irq_o = irq_line;

endmodule

`default_nettype wire

// file: hw/cvc_cfg.svh
// Purpose: offsets, field positions and reset values of the capture block
// Assumes: 32-bit avalon data, byte addresses, word aligned registers
// Notes: definitions only
`ifndef CVC_CFG_SVH
`define CVC_CFG_SVH

// ==========================================================
// register byte offsets
`define CVC_OFF_CTRL 8'h00
`define CVC_OFF_STATUS 8'h04
`define CVC_OFF_CAP_A 8'h08
`define CVC_OFF_CAP_B 8'h0c
`define CVC_OFF_DONE_CLR 8'h10
`define CVC_OFF_IRQ_STAT 8'h14
`define CVC_OFF_IRQ_CLR 8'h18
`define CVC_OFF_IRQ_EN 8'h1c

// ==========================================================
// control word fields
`define CVC_CTRL_RUN 0
`define CVC_CTRL_MOD_LSB 8
`define CVC_CTRL_CHAN_LSB 16
`define CVC_CTRL_TRG_LSB 24
`define CVC_CTRL_RST 32'h0001_0000
`define CVC_CTRL_MASK 32'hffff_ff01

// ==========================================================
// status word fields
`define CVC_ST_ACTIVE 0
`define CVC_ST_DONE_A 1
`define CVC_ST_DONE_B 2
`define CVC_ST_FAULT 3
`define CVC_ST_CNT_RUN 4
`define CVC_ST_TRG 5
`define CVC_ST_CODE_LSB 8

// ==========================================================
// input ranges
`define CVC_TRG_MAX 8'h01
`define CVC_MOD_MAX 8'h1f
`define CVC_CHAN_MIN 8'h01
`define CVC_CHAN_MAX 8'h02

// ==========================================================
// interrupt event bits
`define CVC_IRQ_N 3
`define CVC_IRQ_CAP_A 0
`define CVC_IRQ_CAP_B 1
`define CVC_IRQ_FAULT 2

`endif

// file: hw/cvc_irq.sv
// Purpose: sticky event status, enable mask, level interrupt
// Assumes: set pulses and write strobes on mclk_i
// Notes: a set in the clearing cycle wins
`default_nettype none

module cvc_irq #(
  parameter int unsigned N = 3
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [N-1:0] set_i,
  input wire logic clr_we_i,
  input wire logic en_we_i,
  input wire logic [N-1:0] wdata_i,
  output logic [N-1:0] status_o,
  output logic [N-1:0] enable_o,
  output logic irq_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [N-1:0] stat;
    logic [N-1:0] en;
    logic irq;
  } cvc_irq_s;

  cvc_irq_s q;
  cvc_irq_s d;

  always_comb
  begin
    d = q;
    if (clr_we_i)
    begin
      d.stat = q.stat & ~wdata_i;
    end
    d.stat = d.stat | set_i;
    if (en_we_i)
    begin
      d.en = wdata_i;
    end
    d.irq = |(d.stat & d.en);
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      q <= '0;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  assign status_o = q.stat;
  assign enable_o = q.en;
  assign irq_o = q.irq;

endmodule

`default_nettype wire

// file: hw/cvc_pkg.sv
// Purpose: shared types of the capture block
// Assumes: nothing
// Notes: constants live in cvc_cfg.svh
`default_nettype none

package cvc_pkg;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_FAULT = 2'b10
  } cvc_state_e;

  typedef enum logic [7:0] {
    FC_NONE = 8'h00,
    FC_BAD_TRG = 8'h01,
    FC_BAD_MOD = 8'h02,
    FC_BAD_CHAN = 8'h03,
    FC_NOT_FOUND = 8'h04
  } cvc_fault_e;

  // ==========================================================
  // byte-lane merge for avalon writes
  function automatic logic [31:0] cvc_be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// file: hw/cvc_sync.sv
// Purpose: three-flop synchroniser with agreement filter
// Assumes: inputs asynchronous to mclk_i
// Notes: level moves only when stages two and three agree
`default_nettype none

module cvc_sync #(
  parameter int unsigned W = 3
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } cvc_sync_s;

  cvc_sync_s q;
  cvc_sync_s d;

  // s1 feeds s2 only; the filter looks at s2 and s3
  always_comb
  begin
    d = q;
    d.s1 = async_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (q.s2[i] == q.s3[i])
      begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      q <= '0;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  assign level_o = q.lvl;

endmodule

`default_nettype wire

// file: verif/cvc_capture_sva.sv
// Purpose: port checks of the capture unit
// Assumes: ce_i high whenever the bus is used
// Notes: bound into cvc_capture
`default_nettype none

`include "cvc_cfg.svh"

module cvc_capture_sva (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic irq_o,
  input wire logic ext_capture_i,
  input wire logic compare_hit_a_i,
  input wire logic compare_hit_b_i
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] idle_q;
  logic en_q;
  logic [2:0] pins_q;
  logic wdone;

  assign wdone = avs_write_i && !avs_waitrequest_o;

  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  // =====
  // cycles since last write or event pin change
  always_ff @(posedge mclk_i)
  begin
    pins_q <= {ext_capture_i, compare_hit_a_i, compare_hit_b_i};
    if (srst_i)
      en_q <= 1'b0;
    else if (wdone && avs_address_i == `CVC_OFF_IRQ_EN && avs_writedata_i[2:0] != 3'h0)
      en_q <= 1'b1;
    if (srst_i || wdone || pins_q != {ext_capture_i, compare_hit_a_i, compare_hit_b_i})
      idle_q <= 8'h0;
    else if (idle_q != 8'hff)
      idle_q <= idle_q + 8'h1;
  end

  // =====
  // bus timing
  AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered in one cycle");
  AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  AST_WAIT_IDLE: assert property (!$past(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("answer without request");
  AST_RDATA_HOLD: assert property ($changed(avs_readdata_o) |-> (avs_read_i && !avs_waitrequest_o) || $past(srst_i))
    else $error("read data moved outside a read");
  AST_RESET_IDLE: assert property ($past(srst_i) |-> avs_waitrequest_o && !irq_o && avs_readdata_o == 32'h0)
    else $error("outputs not idle after reset");

  // =====
  // interrupt causes
  AST_IRQ_NEEDS_EN: assert property (irq_o |-> en_q)
    else $error("interrupt without enable");
  AST_IRQ_RISE: assert property ($rose(irq_o) |-> idle_q < 8'h10)
    else $error("interrupt with no cause");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wdone) || $past(wdone, 2))
    else $error("interrupt dropped without a write");
  AST_EVENT_SYNC: assert property ($rose(irq_o) && !$past(wdone) && !$past(wdone, 2) |-> idle_q >= 8'h2)
    else $error("event seen before synchronising");
endmodule

bind cvc_capture cvc_capture_sva u_sva (
  .mclk_i(mclk_i), .srst_i(srst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .ext_capture_i(ext_capture_i),
  .compare_hit_a_i(compare_hit_a_i), .compare_hit_b_i(compare_hit_b_i)
);

`default_nettype wire

// file: verif/cvc_counter_model.sv
// Purpose: running counter of the channel, far side of the capture unit
// Assumes: same clock as the unit
// Notes: load wins over counting
`default_nettype none

module cvc_counter_model (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic load_i,
  input wire logic [31:0] load_value_i,
  output logic [31:0] counter_value_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // =====
  // stopped counter stays frozen, so captures are exact
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      counter_value_o <= 32'h0;
    else if (load_i)
      counter_value_o <= load_value_i;
    else if (run_i)
      counter_value_o <= counter_value_o + 32'h1;
  end
endmodule

`default_nettype wire

// file: verif/tb_counter_value_capture.sv
// Purpose: self-checking bench of the capture unit
// Assumes: counter frozen at a loaded value during each event
// Notes: event waits are fixed; synchroniser needs about four edges
`default_nettype none

`include "cvc_cfg.svh"

module tb_counter_value_capture;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] adr = 8'h0;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic irq_o;
  logic [31:0] cnt;
  logic cnt_run = 1'b0;
  logic cnt_load = 1'b0;
  logic [31:0] cnt_value = 32'h0;
  logic pin = 1'b0;
  logic assigned = 1'b1;
  logic hit_a = 1'b0;
  logic hit_b = 1'b0;
  logic ce = 1'b1;
  logic [31:0] rdata;
  logic [31:0] bad [5] = '{32'h0201_0001, 32'h0001_2001, 32'h0003_0001, 32'h0002_0001, 32'h0001_0101};
  int fail_count = 0;
  int checks_done = 0;

  cvc_capture dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce), .avs_address_i(adr), .avs_read_i(rd_q),
    .avs_write_i(wr_q), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
    .counter_value_i(cnt), .counter_run_i(cnt_run), .ext_capture_i(pin),
    .ext_capture_assigned_i(assigned), .compare_hit_a_i(hit_a), .compare_hit_b_i(hit_b)
  );

  cvc_counter_model u_cnt (
    .mclk_i(mclk_i), .srst_i(srst_i), .run_i(cnt_run), .load_i(cnt_load),
    .load_value_i(cnt_value), .counter_value_o(cnt)
  );

  // =====
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // hold request until waitrequest low is sampled
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    wr_q <= wr;
    rd_q <= !wr;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50)
      fail_count++;
    rdata = avs_readdata_o;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rdata, e);
  endtask

  task automatic ev(input int k, input logic v);
    case (k)
      0: pin <= v;
      1: hit_a <= v;
      default: hit_b <= v;
    endcase
    repeat (10) @(posedge mclk_i);
  endtask

  task automatic load(input logic [31:0] v);
    cnt_value <= v;
    cnt_load <= 1'b1;
    @(posedge mclk_i);
    cnt_load <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // =====
  // clock and watchdog
  initial
  begin
    forever #50 mclk_i = ~mclk_i;
  end

  initial
  begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    results();
  end

  // =====
  // tests
  initial
  begin
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    rc(`CVC_OFF_CTRL, `CVC_CTRL_RST);
    rc(`CVC_OFF_CAP_A, 32'h0);
    rc(`CVC_OFF_CAP_B, 32'h0);
    rc(`CVC_OFF_STATUS, 32'h0);
    rc(8'h24, 32'h0);
    load(32'h55);
    ev(0, 1'b1);
    ev(0, 1'b0);
    rc(`CVC_OFF_CAP_A, 32'h0);
    $display("test reset and idle done");
    bus(1'b1, `CVC_OFF_IRQ_EN, 32'h7);
    bus(1'b1, `CVC_OFF_CTRL, 32'h0001_0001);
    cnt_run <= 1'b1;
    rc(`CVC_OFF_STATUS, 32'h11);
    cnt_run <= 1'b0;
    load(32'hffff_fffb);
    ev(0, 1'b1);
    rc(`CVC_OFF_CAP_A, 32'hffff_fffb);
    rc(`CVC_OFF_STATUS, 32'h3);
    check({31'h0, irq_o}, 32'h1);
    load(32'h64);
    ev(0, 1'b0);
    rc(`CVC_OFF_CAP_B, 32'h64);
    ev(1, 1'b1);
    ev(1, 1'b0);
    rc(`CVC_OFF_CAP_A, 32'hffff_fffb);
    load(32'h7);
    ev(0, 1'b1);
    rc(`CVC_OFF_CAP_A, 32'h7);
    rc(`CVC_OFF_STATUS, 32'h7);
    bus(1'b1, `CVC_OFF_DONE_CLR, 32'h1);
    rc(`CVC_OFF_STATUS, 32'h5);
    rc(`CVC_OFF_IRQ_STAT, 32'h3);
    bus(1'b1, `CVC_OFF_IRQ_CLR, 32'h3);
    check({31'h0, irq_o}, 32'h0);
    // enable low freezes the synchroniser, so a pin pulse inside it goes unseen
    ce <= 1'b0;
    ev(0, 1'b0);
    ev(0, 1'b1);
    ce <= 1'b1;
    rc(`CVC_OFF_STATUS, 32'h5);
    rc(`CVC_OFF_CAP_B, 32'h64);
    $display("test input capture done");
    bus(1'b1, `CVC_OFF_CTRL, 32'h0001_0000);
    rc(`CVC_OFF_STATUS, 32'h0);
    load(32'h99);
    ev(0, 1'b0);
    rc(`CVC_OFF_CAP_B, 32'h64);
    assigned <= 1'b0;
    bus(1'b1, `CVC_OFF_CTRL, 32'h0001_0001);
    ev(0, 1'b1);
    ev(0, 1'b0);
    rc(`CVC_OFF_CAP_A, 32'h7);
    rc(`CVC_OFF_CAP_B, 32'h64);
    assigned <= 1'b1;
    bus(1'b1, `CVC_OFF_CTRL, 32'h0001_0000);
    $display("test stop and unassigned done");
    bus(1'b1, `CVC_OFF_CTRL, 32'h0101_0001);
    load(32'h2);
    ev(0, 1'b1);
    ev(0, 1'b0);
    rc(`CVC_OFF_CAP_A, 32'h7);
    ev(1, 1'b1);
    ev(1, 1'b0);
    rc(`CVC_OFF_CAP_A, 32'h2);
    bus(1'b1, `CVC_OFF_CTRL, 32'h0001_0001);
    rc(`CVC_OFF_STATUS, 32'h23);
    load(32'h3);
    ev(0, 1'b1);
    ev(0, 1'b0);
    ev(2, 1'b1);
    ev(2, 1'b0);
    rc(`CVC_OFF_CAP_B, 32'h3);
    rc(`CVC_OFF_CAP_A, 32'h2);
    bus(1'b1, `CVC_OFF_CTRL, 32'h0001_0000);
    $display("test compare capture done");
    // latched select bit masked: on a fault it keeps the value latched at the last good start
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, `CVC_OFF_CTRL, bad[i]);
      bus(1'b0, `CVC_OFF_STATUS, 32'h0);
      check(rdata & 32'hffff_ffdf, {16'h0, 8'(i < 3 ? i + 1 : 4), 8'h08});
      bus(1'b1, `CVC_OFF_CTRL, 32'h0001_0000);
      bus(1'b0, `CVC_OFF_STATUS, 32'h0);
      check(rdata & 32'hffff_ffdf, 32'h0);
    end
    rc(`CVC_OFF_IRQ_STAT, 32'h7);
    bus(1'b1, `CVC_OFF_IRQ_CLR, 32'h7);
    check({31'h0, irq_o}, 32'h0);
    $display("test faults done");
    results();
  end
endmodule

`default_nettype wire
